// >>> hdl/timer2_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TIMER_TWO_CONTROL_IDX     8'hC8
`define TIMER_TWO_MODE_IDX        8'hC9
`define CAPTURE_RELOAD_LOW_IDX    8'hCA
`define CAPTURE_RELOAD_HIGH_IDX   8'hCB
`define COUNT_LOW_BYTE_IDX        8'hCC
`define COUNT_HIGH_BYTE_IDX       8'hCD

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_OVERFLOW_FLAG_BIT     7
`define CTL_EXTERNAL_FLAG_BIT     6
`define CTL_RX_BAUD_SEL_BIT       5
`define CTL_TX_BAUD_SEL_BIT       4
`define CTL_EXTERNAL_ENABLE_BIT   3
`define CTL_RUN_CONTROL_BIT       2
`define CTL_COUNTER_TIMER_BIT     1
`define CTL_CAPTURE_RELOAD_BIT    0

// ****************************************************************
// Mode register fields
// ****************************************************************
`define MODE_DOWN_COUNT_BIT       0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define BYTE_RESET                8'h00
`define COUNT_ALL_ONES            16'hFFFF
`define BAUD_CLOCKS_PER_TICK      2

`endif

// >>> hdl/timer2_pkg.sv
// Types shared by the timer two design
package timer2_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;

  typedef enum {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_UP_DOWN,
    MODE_BAUD
  } timer_mode_t;

endpackage

// >>> hdl/timer2_capture_reload_baud.sv
// Timer two: capture, auto-reload and baud generation behind APB
// ****************************************************************
// Summary of operation
// - Overflow of the 16-bit count sets the overflow flag.
// - Down-counting, reaching the reload value also sets the overflow flag.
// - Overflow flag is set by hardware only with both baud selects 0.
// - Hardware never clears overflow flag; software may write 0 or 1.
// - External flag set by trigger falling edge or overflow, per mode bits.
// - External flag set by trigger edge stays until software clears it.
// - With interrupt enabled, external flag set raises timer interrupt request.
// - Receive baud select picks timer one or this timer's overflow.
// - Transmit baud select picks timer one or this timer's overflow.
// - Either baud select set forces baud generator mode.
// - External enable 0 ignores trigger edges; 1 lets edge capture or reload.
// - Run control enables counting; clear holds the count bytes except for an enabled trigger-edge reload.
// - Counter/timer select picks internal clocks or external events.
// - Baud generator mode advances once every 2 clocks regardless.
// - In baud mode capture select ignored; reload after every overflow.
// - Capture select 0 reloads on overflow, and on enabled trigger edge unless down-count enabled.
// - Capture select 1 with enable copies count on trigger edge.
// - Down-count enable with trigger level sets count direction.
// - Low capture register takes low byte, gives low reload byte.
// - High capture register takes high byte, gives high reload byte.
// ****************************************************************
`timescale 1ns/1ps
`include "timer2_regs.svh"

module timer2_capture_reload_baud
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              trigger_pin,
  input  wire logic              count_pin,
  input  wire logic              timer1_overflow,
  input  wire logic              timer_int_enable,
  output logic                   timer_irq,
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick
);
  import timer2_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic        overflow_flag;
  logic        external_flag;
  logic        rx_baud_source_select;
  logic        tx_baud_source_select;
  logic        external_enable;
  logic        run_control;
  logic        counter_timer_select;
  logic        capture_reload_select;
  logic        down_count_enable;
  byte_t       count_low_byte;
  byte_t       count_high_byte;
  byte_t       capture_reload_low;
  byte_t       capture_reload_high;
  logic        trigger_prev;
  logic        count_prev;
  logic        baud_phase;
  timer_mode_t mode;
  count_t      count16;
  count_t      reload16;
  count_t      next_count;
  logic        tick;
  logic        trigger_fall;
  logic        ovf_event;
  logic        ext_event;
  logic        cap_event;
  logic        baud_event;
  logic        access;
  logic        done;
  logic        hit;
  logic [31:0] read_value;
  logic        wr_ctl;
  logic        wr_mode;
  logic        wr_rl_low;
  logic        wr_rl_high;
  logic        wr_cnt_low;
  logic        wr_cnt_high;
  logic        wr_hit;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
    reg_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction
  function automatic count_t step16(input count_t v, input logic up);
    step16 = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction

  // ****************************************************************
  // Mode selection and counting
  // ****************************************************************
  assign count16      = {count_high_byte, count_low_byte};
  assign reload16     = {capture_reload_high, capture_reload_low};
  assign trigger_fall = trigger_prev & ~trigger_pin;

  always_comb
  begin
    if (rx_baud_source_select | tx_baud_source_select)
      mode = MODE_BAUD;
    else if (capture_reload_select)
      mode = MODE_CAPTURE;
    else if (down_count_enable)
      mode = MODE_UP_DOWN;
    else
      mode = MODE_RELOAD;
  end

  always_comb
  begin
    if (!run_control)
      tick = 1'b0;
    else if (mode == MODE_BAUD)
      tick = baud_phase;
    else if (counter_timer_select)
      tick = count_prev & ~count_pin;
    else
      tick = 1'b1;
  end

  always_comb
  begin
    next_count = count16;
    ovf_event  = 1'b0;
    ext_event  = 1'b0;
    cap_event  = 1'b0;
    baud_event = 1'b0;
    case (mode)
      MODE_CAPTURE:
      begin
        if (tick)
        begin
          next_count = step16(count16, 1'b1);
          ovf_event  = (count16 == `COUNT_ALL_ONES);
        end
        if (external_enable && trigger_fall)
        begin
          cap_event = 1'b1;
          ext_event = 1'b1;
        end
      end
      MODE_RELOAD,
      MODE_BAUD:
      begin
        if (tick)
        begin
          if (count16 == `COUNT_ALL_ONES)
          begin
            next_count = reload16;
            ovf_event  = (mode == MODE_RELOAD);
            baud_event = (mode == MODE_BAUD);
          end
          else
            next_count = step16(count16, 1'b1);
        end
        if ((mode == MODE_RELOAD) && external_enable && trigger_fall)
        begin
          next_count = reload16;
          ext_event  = 1'b1;
        end
      end
      MODE_UP_DOWN:
      begin
        if (tick && trigger_pin)
        begin
          if (count16 == `COUNT_ALL_ONES)
          begin
            next_count = reload16;
            ovf_event  = 1'b1;
            ext_event  = 1'b1;
          end
          else
            next_count = step16(count16, 1'b1);
        end
        else if (tick)
        begin
          if (count16 == reload16)
          begin
            next_count = `COUNT_ALL_ONES;
            ovf_event  = 1'b1;
            ext_event  = 1'b1;
          end
          else
            next_count = step16(count16, 1'b0);
        end
      end
      default: next_count = count16;
    endcase
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign access = psel & penable;
  assign done   = access & pready;

  always_comb
  begin
    hit        = 1'b1;
    read_value = 32'h0000_0000;
    if (reg_hit(paddr, `TIMER_TWO_CONTROL_IDX))
      read_value = {24'h00_0000, overflow_flag, external_flag,
                    rx_baud_source_select, tx_baud_source_select,
                    external_enable, run_control,
                    counter_timer_select, capture_reload_select};
    else if (reg_hit(paddr, `TIMER_TWO_MODE_IDX))
      read_value = {31'h0000_0000, down_count_enable};
    else if (reg_hit(paddr, `CAPTURE_RELOAD_LOW_IDX))
      read_value = {24'h00_0000, capture_reload_low};
    else if (reg_hit(paddr, `CAPTURE_RELOAD_HIGH_IDX))
      read_value = {24'h00_0000, capture_reload_high};
    else if (reg_hit(paddr, `COUNT_LOW_BYTE_IDX))
      read_value = {24'h00_0000, count_low_byte};
    else if (reg_hit(paddr, `COUNT_HIGH_BYTE_IDX))
      read_value = {24'h00_0000, count_high_byte};
    else
      hit = 1'b0;
  end

  assign wr_hit      = done & pwrite & hit;
  assign wr_ctl      = wr_hit & reg_hit(paddr, `TIMER_TWO_CONTROL_IDX);
  assign wr_mode     = wr_hit & reg_hit(paddr, `TIMER_TWO_MODE_IDX);
  assign wr_rl_low   = wr_hit & reg_hit(paddr, `CAPTURE_RELOAD_LOW_IDX);
  assign wr_rl_high  = wr_hit & reg_hit(paddr, `CAPTURE_RELOAD_HIGH_IDX);
  assign wr_cnt_low  = wr_hit & reg_hit(paddr, `COUNT_LOW_BYTE_IDX);
  assign wr_cnt_high = wr_hit & reg_hit(paddr, `COUNT_HIGH_BYTE_IDX);

  // ****************************************************************
  // APB answer: one wait state
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access & ~pready;
      prdata  <= (access && !pready && !pwrite) ? read_value : 32'h0000_0000;
      pslverr <= access & ~pready & ~hit;
    end
  end

  // ****************************************************************
  // Configuration bits
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_baud_source_select <= 1'b0;
      tx_baud_source_select <= 1'b0;
      external_enable       <= 1'b0;
      run_control           <= 1'b0;
      counter_timer_select  <= 1'b0;
      capture_reload_select <= 1'b0;
      down_count_enable     <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        rx_baud_source_select <= pwdata[`CTL_RX_BAUD_SEL_BIT];
        tx_baud_source_select <= pwdata[`CTL_TX_BAUD_SEL_BIT];
        external_enable       <= pwdata[`CTL_EXTERNAL_ENABLE_BIT];
        run_control           <= pwdata[`CTL_RUN_CONTROL_BIT];
        counter_timer_select  <= pwdata[`CTL_COUNTER_TIMER_BIT];
        capture_reload_select <= pwdata[`CTL_CAPTURE_RELOAD_BIT];
      end
      if (wr_mode)
        down_count_enable <= pwdata[`MODE_DOWN_COUNT_BIT];
    end
  end

  // ****************************************************************
  // Flags: hardware set wins over software clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
    end
    else if (wr_ctl)
    begin
      overflow_flag <= pwdata[`CTL_OVERFLOW_FLAG_BIT] | ovf_event;
      external_flag <= pwdata[`CTL_EXTERNAL_FLAG_BIT] | ext_event;
    end
    else
    begin
      overflow_flag <= overflow_flag | ovf_event;
      external_flag <= external_flag | ext_event;
    end
  end

  // ****************************************************************
  // Count bytes, edge history and baud prescaler
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_low_byte  <= `BYTE_RESET;
      count_high_byte <= `BYTE_RESET;
    end
    else
    begin
      count_low_byte  <= wr_cnt_low  ? pwdata[7:0] : next_count[7:0];
      count_high_byte <= wr_cnt_high ? pwdata[7:0] : next_count[15:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger_prev <= 1'b1;
      count_prev   <= 1'b1;
      baud_phase   <= 1'b0;
    end
    else
    begin
      trigger_prev <= trigger_pin;
      count_prev   <= count_pin;
      baud_phase   <= (mode == MODE_BAUD) & run_control & ~baud_phase;
    end
  end

  // ****************************************************************
  // Capture / reload registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_reload_low  <= `BYTE_RESET;
      capture_reload_high <= `BYTE_RESET;
    end
    else
    begin
      if (wr_rl_low)
        capture_reload_low <= pwdata[7:0];
      else if (cap_event)
        capture_reload_low <= count_low_byte;
      if (wr_rl_high)
        capture_reload_high <= pwdata[7:0];
      else if (cap_event)
        capture_reload_high <= count_high_byte;
    end
  end

  // ****************************************************************
  // Interrupt request and baud ticks
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_irq    <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end
    else
    begin
      timer_irq    <= timer_int_enable & (overflow_flag | external_flag);
      rx_baud_tick <= rx_baud_source_select ? baud_event
                                            : timer1_overflow;
      tx_baud_tick <= tx_baud_source_select ? baud_event
                                            : timer1_overflow;
    end
  end

endmodule

// >>> tb/timer2_asserts.sv
// Port-level checks for the timer two block
`timescale 1ns/1ps
`include "timer2_regs.svh"

module timer2_asserts
#(
  parameter int ADDR_W = 12
)
(
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              timer1_overflow,
  input logic              timer_int_enable,
  input logic              timer_irq,
  input logic              rx_baud_tick,
  input logic              tx_baud_tick
);
  // ****************************************************************
  // Shadow of the baud selects
  // ****************************************************************
  logic rx_sel;
  logic tx_sel;
  logic wr_ctl;

  assign wr_ctl = psel && penable && pready && pwrite
    && paddr == ADDR_W'({`TIMER_TWO_CONTROL_IDX, 2'h0});

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {rx_sel, tx_sel} <= 2'h0;
    else if (wr_ctl)
      {rx_sel, tx_sel} <= pwdata[`CTL_RX_BAUD_SEL_BIT:`CTL_TX_BAUD_SEL_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  rx_source_a: assert property (
    !rx_sel |=> rx_baud_tick == $past(timer1_overflow))
    else $error("rx tick not from timer one");
  tx_source_a: assert property (
    !tx_sel |=> tx_baud_tick == $past(timer1_overflow))
    else $error("tx tick not from timer one");
  baud_pair_a: assert property (
    $past(rx_sel) && $past(tx_sel) |-> tx_baud_tick == rx_baud_tick)
    else $error("tx and rx baud ticks differ");
  baud_gap_a: assert property (
    rx_sel && $past(rx_sel) && rx_baud_tick |=> !rx_baud_tick)
    else $error("baud ticks too close");
  irq_gate_a: assert property (!timer_int_enable [*2] |-> !timer_irq)
    else $error("interrupt while disabled");
  irq_on_write_a: assert property (
    wr_ctl && pwdata[`CTL_EXTERNAL_FLAG_BIT] && timer_int_enable
    ##1 timer_int_enable |=> timer_irq)
    else $error("software flag set gave no interrupt");
  flag_hold_a: assert property (
    timer_irq && timer_int_enable && !$past(wr_ctl) |=> timer_irq)
    else $error("flag cleared without software");

  cover property (wr_ctl && pwdata[`CTL_EXTERNAL_FLAG_BIT]);
  cover property (rx_sel && rx_baud_tick);
  cover property (pready && pslverr);
endmodule

bind timer2_capture_reload_baud timer2_asserts #(.ADDR_W(ADDR_W)) i_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .timer1_overflow, .timer_int_enable, .timer_irq,
  .rx_baud_tick, .tx_baud_tick);

// >>> tb/pin_model.sv
// Far-side pins: trigger, count input and timer one overflow
`timescale 1ns/1ps

module pin_model
(
  input  logic pclk,
  input  logic presetn,
  input  logic trig_req,
  input  logic cnt_req,
  input  logic t1_req,
  input  logic trig_level,
  output logic trigger_pin,
  output logic count_pin,
  output logic timer1_overflow
);
  // ****************************************************************
  // Falling edge shaping: one cycle high, one low, then idle level
  // ****************************************************************
  logic [1:0] trig_st;
  logic [1:0] cnt_st;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trig_st         <= 2'h0;
      cnt_st          <= 2'h0;
      trigger_pin     <= 1'h1;
      count_pin       <= 1'h1;
      timer1_overflow <= 1'h0;
    end
    else
    begin
      timer1_overflow <= t1_req;
      trig_st <= trig_req ? 2'h2 : trig_st - 2'(trig_st != 2'h0);
      cnt_st  <= cnt_req ? 2'h2 : cnt_st - 2'(cnt_st != 2'h0);
      trigger_pin <= (trig_st == 2'h1) ? 1'h0 : (trig_st == 2'h2) | trig_level;
      count_pin   <= cnt_st != 2'h1;
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for timer two over APB
`timescale 1ns/1ps
`include "timer2_regs.svh"

module tb_top;
  import timer2_pkg::*;
  typedef struct {bit wr; byte_t exp; bit err;} note_t;
  localparam byte_t CTL  = `TIMER_TWO_CONTROL_IDX;
  localparam byte_t MODE = `TIMER_TWO_MODE_IDX;
  localparam byte_t RLO  = `CAPTURE_RELOAD_LOW_IDX;
  localparam byte_t CLO  = `COUNT_LOW_BYTE_IDX;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, timer_int_enable = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, trigger_pin, count_pin, timer1_overflow;
  logic        timer_irq, rx_baud_tick, tx_baud_tick;
  logic        trig_req = 1'h0, cnt_req = 1'h0, t1_req = 1'h0;
  logic        trig_level = 1'h1;
  int          errors = 0, tests_run = 0, seed = 67, k;
  byte_t       v;
  count_t      r;
  note_t       notes[$], n;

  always #25 pclk = ~pclk;
  always @(posedge pclk) t1_req <= ($random(seed) & 7) == 0;

  timer2_capture_reload_baud #(.ADDR_W(12)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trigger_pin, .count_pin, .timer1_overflow,
    .timer_int_enable, .timer_irq, .rx_baud_tick, .tx_baud_tick);
  pin_model i_pins (.pclk, .presetn, .trig_req, .cnt_req, .t1_req,
    .trig_level, .trigger_pin, .count_pin, .timer1_overflow);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [11:0] ra(byte_t idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task automatic apb(bit wr, logic [11:0] a, byte_t d, byte_t e, bit er);
    notes.push_back('{wr, e, er});
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($random(seed)), d};
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(byte_t i, byte_t d); apb(1, ra(i), d, 8'h0, 0); endtask
  task automatic rd(byte_t i, byte_t e); apb(0, ra(i), 8'h0, e, 0); endtask
  task automatic wr16(byte_t i, count_t d);
    wr(i, d[7:0]);
    wr(i + 8'h1, d[15:8]);
  endtask
  task automatic rd16(byte_t i, count_t e);
    rd(i, e[7:0]);
    rd(i + 8'h1, e[15:8]);
  endtask

  task automatic fall(bit trig);
    @(posedge pclk);
    trig_req <= trig;
    cnt_req <= !trig;
    @(posedge pclk);
    trig_req <= 1'h0;
    cnt_req <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Answer monitor
  // ****************************************************************
  always @(posedge pclk)
    if (psel === 1'h1 && pready === 1'h1)
    begin
      n = notes.pop_front();
      if (!n.wr)
        chk("prdata", {24'h0, n.exp}, prdata);
      chk("pslverr", 32'(n.err), 32'(pslverr));
    end

  initial
  begin
    repeat (20000) @(posedge pclk);
    chk("watchdog", 32'h0, 32'h1);
    end_sim;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++) rd(CTL + 8'(i), 8'h0);
    apb(0, ra(8'hCE), 8'h0, 8'h0, 1);
    apb(1, ra(CTL) | 12'h1, 8'hFF, 8'h0, 1);
    rd(CTL, 8'h0);
    v = $random(seed);
    wr(MODE, v);
    rd(MODE, {7'h0, v[0]});
    r = $random(seed);
    wr16(RLO, r);
    rd16(RLO, r);
    wr(MODE, 8'h0);
    wr16(CLO, 16'h00FF);
    wr(CTL, 8'h06);
    repeat (3) fall(0);
    wr(CTL, 8'h02);
    fall(0);
    rd16(CLO, 16'h0102);
    timer_int_enable <= 1'h1;
    wr16(RLO, 16'hFFFE);
    wr16(CLO, 16'hFFFF);
    wr(CTL, 8'h04);
    rd(CTL, 8'h84);
    wr(CTL, 8'h80);
    wr(CTL, 8'h00);
    rd(CTL, 8'h00);
    wr(CTL, 8'h40);
    rd(CTL, 8'h40);
    chk("timer_irq", 32'h1, 32'(timer_irq));
    wr16(CLO, 16'h1234);
    wr16(RLO, 16'h0000);
    wr(CTL, 8'h07);
    fall(1);
    rd16(RLO, 16'h0000);
    rd(CTL, 8'h07);
    wr(CTL, 8'h0F);
    fall(1);
    rd(CTL, 8'h4F);
    rd16(RLO, 16'h1234);
    rd(CTL, 8'h4F);
    wr(CTL, 8'h0E);
    wr16(RLO, 16'hABCD);
    fall(1);
    rd(CTL, 8'h4E);
    rd16(CLO, 16'hABCD);
    wr(CTL, 8'h02);
    wr(MODE, 8'h01);
    trig_level <= 1'h0;
    wr16(RLO, 16'h0010);
    wr16(CLO, 16'h0011);
    wr(CTL, 8'h06);
    repeat (2) fall(0);
    rd(CTL, 8'hC6);
    rd16(CLO, 16'hFFFF);
    trig_level <= 1'h1;
    wr(CTL, 8'h06);
    fall(0);
    rd(CTL, 8'hC6);
    rd16(CLO, 16'h0010);
    wr(CTL, 8'h02);
    wr(MODE, 8'h00);
    wr16(CLO, 16'hFFFE);
    wr16(RLO, 16'hFFFE);
    wr(CTL, 8'h37);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (rx_baud_tick !== 1'h1 && k < 50);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (rx_baud_tick !== 1'h1 && k < 50);
    chk("baud period", 32'h4, 32'(k));
    wr(CTL, 8'h33);
    rd(CTL, 8'h33);
    rd16(RLO, 16'hFFFE);
    end_sim;
  end
endmodule
